// File: verilog/asis_pkg.sv
// package: register map, field layout and types of the sequence input select block
package asis_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] SEL_ADDR = 12'h040;
    localparam logic [11:0] END_ADDR = 12'h048;
    localparam logic [11:0] CTRL_ADDR = 12'h04C;
    localparam logic [11:0] STAT_ADDR = 12'h050;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int NUM_STEPS = 8;
    localparam int FIELD_W = 2;
    localparam int STEP_PITCH = 4;
    localparam int STEP_W = 3;
    localparam logic [31:0] SEL_RW_MASK = 32'h3333_3333;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [1:0] FIELD_RESET = 2'h0;
    localparam logic [7:0] END_RESET = 8'h00;
    localparam int CTRL_START_BIT = 0;
    localparam logic [2:0] LAST_STEP = 3'h7;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } asis_wreq_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_WAIT = 2'b10
    } asis_seq_t;

endpackage

// File: verilog/asis_field.sv
// one read/write channel-select field with synchronous reset
`timescale 1ns/100ps
module asis_field #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import asis_pkg::*;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= W'(FIELD_RESET);
        end
        else if (we)
        begin
            q <= d;
        end
    end

endmodule

// File: verilog/asis_top.sv
// sequence input select register, axi4-lite slave and step sequencer
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module asis_top (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [asis_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [asis_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [asis_pkg::FIELD_W-1:0] MUX_SEL,
    output logic CONV_START,
    input wire logic CONV_DONE,
    output logic [asis_pkg::STEP_W-1:0] STEP,
    output logic SEQ_BUSY,
    output logic SEQ_DONE
);
    import asis_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    asis_wreq_t wreq_r;
    logic aw_held_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_go;
    logic wr_sel;
    logic wr_end;
    logic wr_ctrl;
    logic start_req;
    logic [31:0] sel_word;
    logic [1:0] field_q [NUM_STEPS];
    logic [7:0] end_mask_r;
    asis_seq_t state_r;
    logic [STEP_W-1:0] step_r;
    logic [FIELD_W-1:0] mux_sel_r;
    logic conv_start_r;
    logic seq_done_r;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;
    logic last_step;

    // ------------------------------------------------------------
    // axi write channels
    // ------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY = !w_held_r && !bvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            wreq_r <= '0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held_r <= 1'b1;
                wreq_r.addr <= S_AXI_AWADDR;
            end
            else if (wr_go)
            begin
                aw_held_r <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held_r <= 1'b1;
                wreq_r.data <= S_AXI_WDATA;
                wreq_r.strb <= S_AXI_WSTRB;
            end
            else if (wr_go)
            begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel || wr_end || wr_ctrl || wreq_r.addr == STAT_ADDR)
                ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY)
        begin
            bvalid_r <= 1'b0;
        end
    end

    assign wr_sel = wr_go && wreq_r.addr == SEL_ADDR;
    assign wr_end = wr_go && wreq_r.addr == END_ADDR;
    assign wr_ctrl = wr_go && wreq_r.addr == CTRL_ADDR;
    assign start_req = wr_ctrl && wreq_r.strb[0] && wreq_r.data[CTRL_START_BIT];

    // ------------------------------------------------------------
    // channel select fields
    // ------------------------------------------------------------
    // one field per step, four bits apart; the pairs between are never stored
    generate
        for (genvar i = 0; i < NUM_STEPS; i++)
        begin : g_field
            asis_field #(.W(FIELD_W)) u_field (
                .clk(REF_CLK),
                .rst(RST),
                .we(wr_sel && wreq_r.strb[i/2]),
                .d(wreq_r.data[i*STEP_PITCH +: FIELD_W]),
                .q(field_q[i])
            );
            assign sel_word[i*STEP_PITCH +: FIELD_W] = field_q[i];
            assign sel_word[i*STEP_PITCH+FIELD_W +: FIELD_W] = 2'h0;
        end
    endgenerate

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            end_mask_r <= END_RESET;
        end
        else if (wr_end && wreq_r.strb[0])
        begin
            end_mask_r <= wreq_r.data[7:0];
        end
    end

    // ------------------------------------------------------------
    // axi read channels
    // ------------------------------------------------------------
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        case (S_AXI_ARADDR)
            SEL_ADDR: rd_word = sel_word;
            END_ADDR: rd_word = {24'h00_0000, end_mask_r};
            CTRL_ADDR: rd_word = 32'h0000_0000;
            STAT_ADDR: rd_word = {26'h000_0000, MUX_SEL, step_r, state_r == SEQ_WAIT};
            default: rd_resp = RESP_SLVERR;
        endcase
    end

    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_resp;
        end
        else if (S_AXI_RREADY)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // step sequencer
    // ------------------------------------------------------------
    assign last_step = end_mask_r[step_r] || step_r == LAST_STEP;

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state_r <= SEQ_IDLE;
            step_r <= 3'h0;
            mux_sel_r <= FIELD_RESET;
            conv_start_r <= 1'b0;
            seq_done_r <= 1'b0;
        end
        else
        begin
            conv_start_r <= 1'b0;
            seq_done_r <= 1'b0;
            case (state_r)
                SEQ_IDLE:
                begin
                    if (start_req)
                    begin
                        state_r <= SEQ_WAIT;
                        step_r <= 3'h0;
                        mux_sel_r <= field_q[0];
                        conv_start_r <= 1'b1;
                    end
                end
                SEQ_WAIT:
                begin
                    // select held until the converter reports done
                    if (CONV_DONE && !conv_start_r)
                    begin
                        if (last_step)
                        begin
                            state_r <= SEQ_IDLE;
                            seq_done_r <= 1'b1;
                        end
                        else
                        begin
                            step_r <= step_r + 3'h1;
                            mux_sel_r <= field_q[step_r + 3'h1];
                            conv_start_r <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_r <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign MUX_SEL = mux_sel_r;
    assign CONV_START = conv_start_r;
    assign STEP = step_r;
    assign SEQ_BUSY = state_r == SEQ_WAIT;
    assign SEQ_DONE = seq_done_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_step_sel(logic [2:0] k, logic [1:0] f);
        @(posedge REF_CLK) disable iff (RST)
        (CONV_START && STEP == k) |-> MUX_SEL == $past(f);
    endproperty

    AST_STEP8_SEL: assert property (p_step_sel(3'h7, sel_word[29:28]))
        else $error("eighth step select wrong");
    AST_STEP7_SEL: assert property (p_step_sel(3'h6, sel_word[25:24]))
        else $error("seventh step select wrong");
    AST_STEP6_SEL: assert property (p_step_sel(3'h5, sel_word[21:20]))
        else $error("sixth step select wrong");
    AST_STEP5_SEL: assert property (p_step_sel(3'h4, sel_word[17:16]))
        else $error("fifth step select wrong");
    AST_STEP4_SEL: assert property (p_step_sel(3'h3, sel_word[13:12]))
        else $error("fourth step select wrong");
    AST_STEP3_SEL: assert property (p_step_sel(3'h2, sel_word[9:8]))
        else $error("third step select wrong");
    AST_STEP2_SEL: assert property (p_step_sel(3'h1, sel_word[5:4]))
        else $error("second step select wrong");
    AST_STEP1_SEL: assert property (p_step_sel(3'h0, sel_word[1:0]))
        else $error("first step select wrong");

    AST_RSVD_ZERO: assert property (@(posedge REF_CLK) disable iff (RST)
        (S_AXI_RVALID && $past(S_AXI_ARADDR) == SEL_ADDR && $rose(S_AXI_RVALID))
        |-> (S_AXI_RDATA & ~SEL_RW_MASK) == 32'h0000_0000)
        else $error("reserved bits not zero");

    AST_RESET_ZERO: assert property (@(posedge REF_CLK)
        $fell(RST) |-> sel_word == SEL_RESET && MUX_SEL == 2'h0)
        else $error("fields not zero after reset");

    AST_WRITE_LANDS: assert property (@(posedge REF_CLK) disable iff (RST)
        (wr_sel && wreq_r.strb == 4'hF) |=> sel_word == ($past(wreq_r.data) & SEL_RW_MASK))
        else $error("select write not stored");

    AST_END_STOP: assert property (@(posedge REF_CLK) disable iff (RST)
        (SEQ_BUSY && CONV_DONE && !CONV_START && end_mask_r[STEP])
        |=> !SEQ_BUSY && !CONV_START ##1 !CONV_START)
        else $error("sequence ran past end step");

    AST_SEL_HOLD: assert property (@(posedge REF_CLK) disable iff (RST)
        (SEQ_BUSY && !CONV_START && !CONV_DONE) |=> $stable(MUX_SEL) && $stable(STEP))
        else $error("select moved during conversion");

    AST_BRESP_TIME: assert property (@(posedge REF_CLK) disable iff (RST)
        wr_go |=> S_AXI_BVALID)
        else $error("write answer late");

    AST_READ_TIME: assert property (@(posedge REF_CLK) disable iff (RST)
        (S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID)
        else $error("read answer late");

    AST_START_PULSE: assert property (@(posedge REF_CLK) disable iff (RST)
        CONV_START |=> !CONV_START)
        else $error("start longer than one cycle");

    AST_DONE_IDLE: assert property (@(posedge REF_CLK) disable iff (RST)
        SEQ_DONE |-> !SEQ_BUSY && !CONV_START)
        else $error("sequence busy at done");

    C_FULL_RUN: cover property (@(posedge REF_CLK) disable iff (RST)
        CONV_START && STEP == 3'h7);
    C_EARLY_END: cover property (@(posedge REF_CLK) disable iff (RST)
        SEQ_DONE && $past(STEP) == 3'h3);
    C_SEL_WRITE: cover property (@(posedge REF_CLK) disable iff (RST) wr_sel);
    C_HELD_SEL: cover property (@(posedge REF_CLK) disable iff (RST)
        SEQ_BUSY && !CONV_START && !CONV_DONE);

endmodule

// File: tb/asis_conv_model.sv
// converter stand-in: answers each conversion start with a one-cycle done
`timescale 1ns/100ps
module asis_conv_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic conv_start,
    input wire logic slow,
    output logic conv_done
);
    logic [3:0] wait_r;
    logic busy_r;
    // done never overlaps the start cycle; slow mode stretches the conversion
    always_ff @(posedge clk)
    begin
        conv_done <= 1'b0;
        if (rst)
            busy_r <= 1'b0;
        else if (conv_start)
        begin
            busy_r <= 1'b1;
            wait_r <= slow ? 4'h6 : 4'h1;
        end
        else if (busy_r && wait_r == 4'h0)
        begin
            busy_r <= 1'b0;
            conv_done <= 1'b1;
        end
        else if (busy_r)
            wait_r <= wait_r - 4'h1;
    end
endmodule

// File: tb/test_adc_sequence_input_select.sv
// testbench: register access and step sequencing of the input select block
`timescale 1ns/100ps
module test_adc_sequence_input_select;
    import asis_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic slow = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done, seq_busy, seq_done;
    logic [1:0] bresp, rresp, mux_sel;
    logic [31:0] rdata;
    logic [2:0] step;
    logic [15:0] lfsr_r = 16'h0041;
    logic [33:0] rd_q[$];
    logic [4:0] cv_q[$];
    logic [1:0] wr_q[$];
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;

    always #4 clk = ~clk;

    asis_top i_dut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .MUX_SEL(mux_sel), .CONV_START(conv_start), .CONV_DONE(conv_done), .STEP(step),
        .SEQ_BUSY(seq_busy), .SEQ_DONE(seq_done));

    asis_conv_model i_conv (.clk(clk), .rst(rst), .conv_start(conv_start), .slow(slow),
        .conv_done(conv_done));

    // ------------------------------------------------------------
    // helpers and bus tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic next_rand(output logic [31:0] v);
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        v[15:0] = lfsr_r;
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        v[31:16] = lfsr_r;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        wr_q.push_back(er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        rd_q.push_back({er, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic run_seq(input logic [31:0] sel, input logic [7:0] ends, input int last);
        wr(SEL_ADDR, sel, 4'hF, RESP_OKAY);
        wr(END_ADDR, 32'(ends), 4'hF, RESP_OKAY);
        for (int k = 0; k <= last; k++)
            cv_q.push_back({k[2:0], sel[4*k +: 2]});
        wr(CTRL_ADDR, 32'h0000_0001, 4'h1, RESP_OKAY);
        // second start while busy must not restart the sequence
        wr(CTRL_ADDR, 32'h0000_0001, 4'h1, RESP_OKAY);
        do @(posedge clk); while (seq_done !== 1'b1);
        check("busy at end", 32'h0000_0000, 32'(seq_busy));
        repeat (4) @(posedge clk);
        check("steps left", 32'h0000_0000, 32'(cv_q.size()));
        rd(STAT_ADDR, {26'h0, sel[4*last +: 2], last[2:0], 1'b0}, RESP_OKAY);
    endtask

    // ------------------------------------------------------------
    // result watchers
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        logic [33:0] e;
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            if (rd_q.size() == 0)
                check("unexpected read", 32'h0000_0000, 32'h0000_0001);
            else
            begin
                e = rd_q.pop_front();
                check("read data", e[31:0], rdata);
                check("read response", 32'(e[33:32]), 32'(rresp));
            end
        end
    end

    always @(posedge clk)
    begin
        logic [1:0] eb;
        if (bvalid === 1'b1 && bready === 1'b1)
        begin
            if (wr_q.size() == 0)
                check("unexpected write answer", 32'h0000_0000, 32'h0000_0001);
            else
            begin
                eb = wr_q.pop_front();
                check("write response", 32'(eb), 32'(bresp));
            end
        end
    end

    always @(posedge clk)
    begin
        logic [4:0] cur;
        if (conv_start === 1'b1)
        begin
            if (cv_q.size() == 0)
                check("extra step", 32'h0000_0000, 32'h0000_0001);
            else
            begin
                cur = cv_q.pop_front();
                check("step and select", 32'(cur), 32'({step, mux_sel}));
                check("busy during step", 32'h0000_0001, 32'(seq_busy));
            end
        end
        if (conv_done === 1'b1 && seq_busy === 1'b1)
            check("held select", 32'(cur[1:0]), 32'(mux_sel));
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] pat;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(SEL_ADDR, SEL_RESET, RESP_OKAY);
        rd(STAT_ADDR, 32'h0000_0000, RESP_OKAY);
        wr(SEL_ADDR, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(SEL_ADDR, SEL_RW_MASK, RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            next_rand(pat);
            wr(SEL_ADDR, pat, 4'hF, RESP_OKAY);
            rd(SEL_ADDR, pat & SEL_RW_MASK, RESP_OKAY);
        end
        // software update keeps reserved bits as read, touches only byte 1
        wr(SEL_ADDR, pat & SEL_RW_MASK & 32'hFFFF_00FF, 4'h2, RESP_OKAY);
        rd(SEL_ADDR, pat & SEL_RW_MASK & 32'hFFFF_00FF, RESP_OKAY);
        wr(12'h0F0, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        rd(12'h0F0, 32'h0000_0000, RESP_SLVERR);
        wr(STAT_ADDR, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(STAT_ADDR, 32'h0000_0000, RESP_OKAY);
        rd(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
        rd(SEL_ADDR, pat & SEL_RW_MASK & 32'hFFFF_00FF, RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            next_rand(pat);
            slow <= i[0];
            if (i < 2)
                run_seq(pat, 8'h00, 7);
            else
                run_seq(pat | 32'h3330_0000, 8'h48, 3);
        end
        repeat (4) @(posedge clk);
        // reset after the last run has finished must clear the fields written above
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(SEL_ADDR, SEL_RESET, RESP_OKAY);
        rd(END_ADDR, 32'(END_RESET), RESP_OKAY);
        rd(STAT_ADDR, 32'h0000_0000, RESP_OKAY);
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule
